/* core/tdm_link_pkg.sv */
// Operation
// - disabled link sends mark unless receive loopback is set, gives core no received data
// - disable clears frame lock status
// - enabled link transmits full frames with management
// - enabled link locks on valid framing
// - rate write drops lock until clock matches
// - rate write resizes map, keeps assignments
// - assignments beyond shrunk frame lose path
// - composite rts from configuration bit only
// - composite dtr on from reset
// - receive and transmit loopback exclusive
// - receive loopback drives received data out
// - transmit loopback feeds transmit into receive
// - channel rates 1200 to 64000, fit bandwidth
// - high-speed interface forces synchronous timing
// - external clock samples txd on txce
// - cts follows rts delayed, or fixed
// - default dcd follows frame lock
// - alternative dcd follows far-end rts
// - local loop: txd to rxd, mark out
// - remote loop: channel returned, rxd mark
// - both channel loops may apply together
// - cts delay 0,3,7,13,26,53 ms
// - 400 frames per second, length scales
// - far-end rts dcd adds one slot
package tdm_link_pkg;
   localparam int CLK_PERIOD_NS = 5;
   localparam int MS_NS = 1000000;
   localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
   localparam int CLK_HZ = 200000000;
   localparam int LINK_STEP_HZ = 8000;
   localparam int LINK_BASE_CYC = CLK_HZ / LINK_STEP_HZ;
   localparam int FRAME_HZ = 400;
   localparam logic [8:0] BITS_PER_STEP = 9'(LINK_STEP_HZ / FRAME_HZ);
   localparam logic [8:0] OVH_SLOTS = 9'(1600 / FRAME_HZ);
   localparam logic [8:0] MGMT_SLOTS = 9'(1200 / FRAME_HZ);
   // register offsets (byte addresses)
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] RATE_OFF = 8'h04;
   localparam logic [7:0] STAT_OFF = 8'h08;
   localparam logic [7:0] FRAME_OFF = 8'h0c;
   localparam logic [7:0] CH_BASE = 8'h40;
   localparam int CH_STRIDE_SH = 3;
   // control bits
   localparam int CTRL_EN = 0;
   localparam int CTRL_RTS = 1;
   localparam int CTRL_RXLP = 2;
   localparam int CTRL_TXLP = 3;
   // status bits
   localparam int ST_LOCK = 0;
   localparam int ST_RATE_OK = 1;
   localparam int ST_LOST = 2;
   localparam int ST_BW_OK = 3;
   // channel config fields
   localparam int CF_RATE_LSB = 0;
   localparam int CF_HS = 4;
   localparam int CF_SYNC = 5;
   localparam int CF_EXTCLK = 6;
   localparam int CF_CTS_LSB = 7;
   localparam int CF_DLY_LSB = 9;
   localparam int CF_DCDFAR = 12;
   localparam int CF_LLOOP = 13;
   localparam int CF_RLOOP = 14;
   localparam int CF_W = 15;
   localparam logic [1:0] CTS_FOLLOW = 2'h0;
   localparam logic [1:0] CTS_ON = 2'h1;
   localparam logic [4:0] RATE_RST = 5'h01;
   localparam logic [3:0] ASYNC_MAX_CODE = 4'h8;

   // slots per frame for each rate code (rate / 400)
   function automatic logic [8:0] rate_slots(input logic [3:0] code);
      case (code)
         4'h0: rate_slots = 9'h003;
         4'h1: rate_slots = 9'h006;
         4'h2: rate_slots = 9'h00c;
         4'h3: rate_slots = 9'h012;
         4'h4: rate_slots = 9'h018;
         4'h5: rate_slots = 9'h024;
         4'h6: rate_slots = 9'h030;
         4'h7: rate_slots = 9'h048;
         4'h8: rate_slots = 9'h060;
         4'h9: rate_slots = 9'h078;
         4'ha: rate_slots = 9'h0a0;
         default: rate_slots = 9'h000;
      endcase
   endfunction : rate_slots

   function automatic logic [5:0] delay_ms(input logic [2:0] sel);
      case (sel)
         3'h0: delay_ms = 6'h00;
         3'h1: delay_ms = 6'h03;
         3'h2: delay_ms = 6'h07;
         3'h3: delay_ms = 6'h0d;
         3'h4: delay_ms = 6'h1a;
         default: delay_ms = 6'h35;
      endcase
   endfunction : delay_ms
endpackage : tdm_link_pkg

/* core/tdm_port_link_control.sv */
`timescale 1ns/1ps
module tdm_port_link_control #(
   parameter int NCH = 16,
   parameter int MS_CYCLES = tdm_link_pkg::MS_CYC,
   parameter int LINK_BASE = tdm_link_pkg::LINK_BASE_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // composite port pins
   input wire logic comp_rxc_i,
   input wire logic comp_rxd_i,
   output logic comp_txd_o,
   output logic comp_rts_o,
   output logic comp_dtr_o,
   // mux core, same clock
   input wire logic core_tx_bit_i,
   input wire logic core_framing_ok_i,
   output logic core_rx_bit_o,
   output logic core_rx_valid_o,
   output logic core_bit_tick_o,
   output logic [8:0] core_slot_o,
   output logic core_frame_start_o,
   output logic core_mgmt_slot_o,
   output logic frame_lock_o,
   output logic [NCH-1:0] ch_path_valid_o,
   output logic [NCH*9-1:0] ch_start_o,
   output logic [NCH*9-1:0] ch_len_o,
   output logic [NCH-1:0] ch_sync_o,
   input wire logic [NCH-1:0] ch_txc_en_i,
   input wire logic [NCH-1:0] ch_from_link_i,
   input wire logic [NCH-1:0] ch_far_rts_i,
   output logic [NCH-1:0] ch_to_link_o,
   // channel port pins
   input wire logic [NCH-1:0] port_txd_i,
   input wire logic [NCH-1:0] port_txce_i,
   input wire logic [NCH-1:0] port_rts_i,
   output logic [NCH-1:0] port_rxd_o,
   output logic [NCH-1:0] port_cts_o,
   output logic [NCH-1:0] port_dcd_o
);
   //--------------------------------------------------------------
   // registers and bus
   //--------------------------------------------------------------
   logic [3:0] ctrl_reg;
   logic [4:0] rate_reg;
   logic lost_reg;
   logic lock_reg;
   logic rate_ok_reg;
   logic rate_wr;
   logic [8:0] frame_size;
   logic [tdm_link_pkg::CF_W-1:0] cfg_reg [NCH];
   logic [NCH-1:0] alloc_reg;
   logic [8:0] start_reg [NCH];
   logic [8:0] slots [NCH];
   logic [11:0] bw_sum;
   logic bw_ok;
   logic wb_req;
   logic wr_en;
   logic [7:0] ch_off;
   logic [3:0] ch_idx;
   logic ch_hit;
   logic [31:0] rd_data;

   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_en = wb_req & wb_we_i & wb_sel_i[0];
   assign ch_off = wb_adr_i - tdm_link_pkg::CH_BASE;
   assign ch_idx = ch_off[tdm_link_pkg::CH_STRIDE_SH +: 4];
   assign ch_hit = (wb_adr_i >= tdm_link_pkg::CH_BASE) && (int'(ch_idx) < NCH)
      && (ch_off[7:tdm_link_pkg::CH_STRIDE_SH] < 5'(NCH)) && (wb_adr_i[1:0] == 2'h0);
   assign rate_wr = wr_en && (wb_adr_i == tdm_link_pkg::RATE_OFF);
   assign frame_size = 9'(rate_reg) * tdm_link_pkg::BITS_PER_STEP;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= 4'h0;
      end else if (wr_en && wb_adr_i == tdm_link_pkg::CTRL_OFF) begin
         ctrl_reg[tdm_link_pkg::CTRL_EN] <= wb_dat_i[tdm_link_pkg::CTRL_EN];
         ctrl_reg[tdm_link_pkg::CTRL_RTS] <= wb_dat_i[tdm_link_pkg::CTRL_RTS];
         ctrl_reg[tdm_link_pkg::CTRL_RXLP] <= wb_dat_i[tdm_link_pkg::CTRL_RXLP];
         ctrl_reg[tdm_link_pkg::CTRL_TXLP] <= wb_dat_i[tdm_link_pkg::CTRL_TXLP]
            & ~wb_dat_i[tdm_link_pkg::CTRL_RXLP];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rate_reg <= tdm_link_pkg::RATE_RST;
      end else if (rate_wr && wb_dat_i[4:0] != 5'h00 && wb_dat_i[4:0] <= 5'h10) begin
         rate_reg <= wb_dat_i[4:0];
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      if (ch_hit) begin
         if (ch_off[2] == 1'b0) begin
            rd_data[tdm_link_pkg::CF_W-1:0] = cfg_reg[ch_idx];
         end else begin
            rd_data[9:0] = {start_reg[ch_idx], alloc_reg[ch_idx]};
            rd_data[16] = ch_path_valid_o[ch_idx];
         end
      end else begin
         case (wb_adr_i)
            tdm_link_pkg::CTRL_OFF: rd_data[3:0] = ctrl_reg;
            tdm_link_pkg::RATE_OFF: rd_data[4:0] = rate_reg;
            tdm_link_pkg::STAT_OFF: begin
               rd_data[tdm_link_pkg::ST_LOCK] = lock_reg;
               rd_data[tdm_link_pkg::ST_RATE_OK] = rate_ok_reg;
               rd_data[tdm_link_pkg::ST_LOST] = lost_reg;
               rd_data[tdm_link_pkg::ST_BW_OK] = bw_ok;
            end
            tdm_link_pkg::FRAME_OFF: begin
               rd_data[8:0] = frame_size;
               rd_data[27:16] = bw_sum;
            end
            default: rd_data = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_req) begin
         wb_dat_o <= rd_data;
      end
   end

   //--------------------------------------------------------------
   // composite link clock measurement
   //--------------------------------------------------------------
   logic [2:0] rxc_sync;
   logic [1:0] rxd_sync;
   logic link_edge;
   logic [16:0] period_cnt;
   logic [21:0] period_scaled;
   logic [21:0] base_w;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rxc_sync <= 3'h0;
         rxd_sync <= 2'h3;
      end else begin
         rxc_sync <= {rxc_sync[1:0], comp_rxc_i};
         rxd_sync <= {rxd_sync[0], comp_rxd_i};
      end
   end

   assign link_edge = rxc_sync[1] & ~rxc_sync[2];
   assign base_w = 22'(LINK_BASE);
   assign period_scaled = 22'(period_cnt) * 22'(rate_reg);

   always_ff @(posedge clk_i) begin
      if (rst_i || rate_wr) begin
         period_cnt <= 17'h0_0000;
         rate_ok_reg <= 1'b0;
      end else if (link_edge) begin
         period_cnt <= 17'h0_0001;
         // a sixteenth tolerance absorbs sampling jitter of one clock
         rate_ok_reg <= (period_scaled + (base_w >> 4) >= base_w)
            && (period_scaled <= base_w + (base_w >> 4));
      end else if (period_cnt[16]) begin
         // link clock stopped: no longer a valid rate
         rate_ok_reg <= 1'b0;
      end else begin
         period_cnt <= period_cnt + 17'h0_0001;
      end
   end

   //--------------------------------------------------------------
   // frame timing and lock
   //--------------------------------------------------------------
   logic [8:0] slot_cnt;
   logic en;

   assign en = ctrl_reg[tdm_link_pkg::CTRL_EN];

   always_ff @(posedge clk_i) begin
      if (rst_i || !en) begin
         slot_cnt <= 9'h000;
         core_frame_start_o <= 1'b0;
         core_mgmt_slot_o <= 1'b0;
         core_bit_tick_o <= 1'b0;
         core_slot_o <= 9'h000;
      end else begin
         core_bit_tick_o <= link_edge;
         core_frame_start_o <= link_edge && slot_cnt == 9'h000;
         core_mgmt_slot_o <= link_edge && slot_cnt != 9'h000
            && slot_cnt <= tdm_link_pkg::MGMT_SLOTS;
         if (link_edge) begin
            core_slot_o <= slot_cnt;
            slot_cnt <= (slot_cnt + 9'h001 >= frame_size) ? 9'h000 : slot_cnt + 9'h001;
         end
      end
   end

   // lock needs enable, rate and framing
   always_ff @(posedge clk_i) begin
      if (rst_i || !en || rate_wr) begin
         lock_reg <= 1'b0;
      end else begin
         lock_reg <= rate_ok_reg & core_framing_ok_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lost_reg <= 1'b0;
      end else if (lock_reg && !(en && !rate_wr && rate_ok_reg && core_framing_ok_i)) begin
         lost_reg <= 1'b1;
      end else if (wr_en && wb_adr_i == tdm_link_pkg::STAT_OFF
            && wb_dat_i[tdm_link_pkg::ST_LOST]) begin
         lost_reg <= 1'b0;
      end
   end

   //--------------------------------------------------------------
   // composite data paths and leads
   //--------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         comp_txd_o <= 1'b1;
         core_rx_bit_o <= 1'b1;
         core_rx_valid_o <= 1'b0;
         comp_rts_o <= 1'b0;
         comp_dtr_o <= 1'b0;
         frame_lock_o <= 1'b0;
      end else begin
         comp_dtr_o <= 1'b1;
         comp_rts_o <= ctrl_reg[tdm_link_pkg::CTRL_RTS];
         frame_lock_o <= lock_reg;
         if (ctrl_reg[tdm_link_pkg::CTRL_RXLP]) begin
            comp_txd_o <= rxd_sync[1];
         end else begin
            comp_txd_o <= en ? core_tx_bit_i : 1'b1;
         end
         core_rx_valid_o <= en & link_edge;
         if (!en) begin
            core_rx_bit_o <= 1'b1;
         end else if (ctrl_reg[tdm_link_pkg::CTRL_TXLP]) begin
            core_rx_bit_o <= core_tx_bit_i;
         end else begin
            core_rx_bit_o <= rxd_sync[1];
         end
      end
   end

   //--------------------------------------------------------------
   // millisecond tick for cts delays
   //--------------------------------------------------------------
   logic [$clog2(MS_CYCLES+1)-1:0] ms_cnt;
   logic ms_tick;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ms_cnt <= '0;
         ms_tick <= 1'b0;
      end else begin
         ms_tick <= (ms_cnt == ($bits(ms_cnt))'(MS_CYCLES - 1));
         ms_cnt <= (ms_cnt == ($bits(ms_cnt))'(MS_CYCLES - 1)) ? '0 : ms_cnt + 1'b1;
      end
   end

   //--------------------------------------------------------------
   // bandwidth total
   //--------------------------------------------------------------
   // allocated slots must fit frame
   always_comb begin
      bw_sum = 12'(tdm_link_pkg::OVH_SLOTS);
      for (int i = 0; i < NCH; i++) begin
         if (alloc_reg[i]) begin
            bw_sum = bw_sum + 12'(slots[i]);
         end
      end
   end
   assign bw_ok = bw_sum <= 12'(frame_size);

   //--------------------------------------------------------------
   // channel ports
   //--------------------------------------------------------------
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic [1:0] txd_s;
      logic [1:0] rts_s;
      logic [2:0] txce_s;
      logic tx_bit_reg;
      logic [5:0] dly_cnt;
      logic [tdm_link_pkg::CF_W-1:0] cfg;
      logic cfg_wr;
      logic alloc_wr;
      logic [9:0] end_slot;
      logic lloop;
      logic rloop;

      assign cfg = cfg_reg[c];
      assign cfg_wr = wr_en && ch_hit && int'(ch_idx) == c && !ch_off[2];
      assign alloc_wr = wr_en && ch_hit && int'(ch_idx) == c && ch_off[2];
      assign lloop = cfg[tdm_link_pkg::CF_LLOOP];
      assign rloop = cfg[tdm_link_pkg::CF_RLOOP];
      assign slots[c] = tdm_link_pkg::rate_slots(cfg[tdm_link_pkg::CF_RATE_LSB +: 4])
         + {8'h00, cfg[tdm_link_pkg::CF_DCDFAR]};
      assign end_slot = {1'b0, start_reg[c]} + {1'b0, slots[c]};

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cfg_reg[c] <= '0;
         end else if (cfg_wr) begin
            cfg_reg[c] <= wb_dat_i[tdm_link_pkg::CF_W-1:0];
            cfg_reg[c][tdm_link_pkg::CF_SYNC] <= wb_dat_i[tdm_link_pkg::CF_SYNC]
               | wb_dat_i[tdm_link_pkg::CF_HS];
            // async tops out at the lower rates
            if (!(wb_dat_i[tdm_link_pkg::CF_SYNC] | wb_dat_i[tdm_link_pkg::CF_HS])
                  && wb_dat_i[3:0] > tdm_link_pkg::ASYNC_MAX_CODE) begin
               cfg_reg[c][3:0] <= tdm_link_pkg::ASYNC_MAX_CODE;
            end
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            alloc_reg[c] <= 1'b0;
            start_reg[c] <= 9'h000;
         end else if (alloc_wr) begin
            alloc_reg[c] <= wb_dat_i[0];
            start_reg[c] <= wb_dat_i[9:1];
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            txd_s <= 2'h3;
            rts_s <= 2'h0;
            txce_s <= 3'h0;
         end else begin
            txd_s <= {txd_s[0], port_txd_i[c]};
            rts_s <= {rts_s[0], port_rts_i[c]};
            txce_s <= {txce_s[1:0], port_txce_i[c]};
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            tx_bit_reg <= 1'b1;
         end else if (cfg[tdm_link_pkg::CF_EXTCLK] ? (txce_s[1] & ~txce_s[2])
               : ch_txc_en_i[c]) begin
            tx_bit_reg <= txd_s[1];
         end
      end

      // delay counts in ms, drop is immediate
      always_ff @(posedge clk_i) begin
         if (rst_i || !rts_s[1]) begin
            dly_cnt <= 6'h00;
         end else if (ms_tick && dly_cnt != 6'h3f) begin
            dly_cnt <= dly_cnt + 6'h01;
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            port_cts_o[c] <= 1'b0;
            port_dcd_o[c] <= 1'b0;
            port_rxd_o[c] <= 1'b1;
            ch_to_link_o[c] <= 1'b1;
            ch_path_valid_o[c] <= 1'b0;
            ch_start_o[c*9 +: 9] <= 9'h000;
            ch_len_o[c*9 +: 9] <= 9'h000;
            ch_sync_o[c] <= 1'b0;
         end else begin
            case (cfg[tdm_link_pkg::CF_CTS_LSB +: 2])
               tdm_link_pkg::CTS_FOLLOW: port_cts_o[c] <= rts_s[1] && dly_cnt
                  >= tdm_link_pkg::delay_ms(cfg[tdm_link_pkg::CF_DLY_LSB +: 3]);
               tdm_link_pkg::CTS_ON: port_cts_o[c] <= 1'b1;
               default: port_cts_o[c] <= 1'b0;
            endcase
            port_dcd_o[c] <= cfg[tdm_link_pkg::CF_DCDFAR] ? ch_far_rts_i[c] : lock_reg;
            port_rxd_o[c] <= lloop ? txd_s[1] : (rloop ? 1'b1 : ch_from_link_i[c]);
            ch_to_link_o[c] <= rloop ? ch_from_link_i[c] : (lloop ? 1'b1 : tx_bit_reg);
            // slots past frame end lose path
            ch_path_valid_o[c] <= alloc_reg[c] && start_reg[c] >= tdm_link_pkg::OVH_SLOTS
               && end_slot <= {1'b0, frame_size};
            ch_start_o[c*9 +: 9] <= start_reg[c];
            ch_len_o[c*9 +: 9] <= slots[c];
            ch_sync_o[c] <= cfg[tdm_link_pkg::CF_SYNC];
         end
      end
   end
endmodule : tdm_port_link_control

/* verif/dce_link_model.sv */
`timescale 1ns/1ps
module dce_link_model (
   input wire logic run_i,
   input wire logic data_i,
   output logic rxc_o,
   output logic rxd_o
);
   // ------------------------------
   // link clock and data
   // ------------------------------
   // one 8 MHz step (125 ns period, 25 clocks), clock still while stopped
   initial begin
      rxc_o = 1'b0;
      rxd_o = 1'b1;
      #3;
      forever begin
         #62.5;
         rxc_o = run_i ? ~rxc_o : 1'b0;
      end
   end
   always @(negedge rxc_o) begin
      rxd_o <= data_i;
   end
   // released line toggles so a stale level cannot pass
   always #5 begin
      if (!run_i) begin
         rxd_o = ~rxd_o;
      end
   end
endmodule : dce_link_model

/* verif/tdm_link_asserts.sv */
`timescale 1ns/1ps
module tdm_link_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic comp_txd_o,
   input wire logic comp_rts_o,
   input wire logic comp_dtr_o,
   input wire logic core_framing_ok_i,
   input wire logic core_rx_valid_o,
   input wire logic core_bit_tick_o,
   input wire logic [8:0] core_slot_o,
   input wire logic core_frame_start_o,
   input wire logic core_mgmt_slot_o,
   input wire logic frame_lock_o
);
   // ------------------------------
   // write decode and enable shadow
   // ------------------------------
   logic wr;
   logic ctrl_w;
   logic rate_w;
   logic en_q;
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
   assign ctrl_w = wr && (wb_adr_i == tdm_link_pkg::CTRL_OFF);
   assign rate_w = wr && (wb_adr_i == tdm_link_pkg::RATE_OFF);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_q <= 1'b0;
      end else if (ctrl_w) begin
         en_q <= wb_dat_i[0];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence link_off;
      (!en_q) [*4];
   endsequence
   sequence disable_wr;
      ctrl_w && !wb_dat_i[0];
   endsequence
   // ------------------------------
   // properties
   // ------------------------------
   a_dtr_on: assert property (!$past(rst_i) && !$past(rst_i, 2) |-> comp_dtr_o)
      else $error("dtr low after reset");
   // rts passes control register then output register: two edges late
   a_rts_cfg: assert property (ctrl_w |-> ##2 comp_rts_o == $past(wb_dat_i[1], 2))
      else $error("rts not taken from control write");
   a_rts_hold: assert property ($changed(comp_rts_o) |-> $past(ctrl_w, 2))
      else $error("rts moved without control write");
   // disable reaches lock register one edge after the control register, lock output one edge later
   a_dis_unlock: assert property (disable_wr |-> ##3 !frame_lock_o)
      else $error("lock kept after disable");
   a_rate_unlock: assert property (rate_w |-> ##2 !frame_lock_o)
      else $error("lock kept after rate write");
   a_lock_framing: assert property (frame_lock_o |-> $past(core_framing_ok_i, 2))
      else $error("lock without framing");
   a_off_quiet: assert property (link_off |-> comp_txd_o && !core_rx_valid_o)
      else $error("disabled link active");
   a_frame_slot: assert property (core_frame_start_o |-> core_bit_tick_o && core_slot_o == 9'h000)
      else $error("frame start off slot zero");
   a_mgmt_slot: assert property (core_mgmt_slot_o |-> core_slot_o inside {9'h001, 9'h002, 9'h003})
      else $error("management slot misplaced");
endmodule : tdm_link_asserts
bind tdm_port_link_control tdm_link_asserts u_tdm_link_asserts (.*);

/* verif/tdm_port_link_control_tb.sv */
`timescale 1ns/1ps
module tdm_port_link_control_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc, stb, we, ack, rxc, rxd, txd, rts, dtr, tx_bit, fr_ok, rx_bit, rx_val, lock;
   logic run, ldata;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, dat_o, rdat;
   logic [15:0] pval, sync, txc, from_l, far_rts, to_l, ptxd, ptxce, prts, prxd, cts, dcd;
   logic [2:0] erx = 3'b010;
   logic [2:0] etl = 3'b001;
   int n_tests = 0;
   int bad_count = 0;
   always #2.5 clk_i = ~clk_i;
   tdm_port_link_control #(.NCH(16), .MS_CYCLES(20), .LINK_BASE(25)) u_tdm_port_link_control (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .comp_rxc_i(rxc), .comp_rxd_i(rxd), .comp_txd_o(txd), .comp_rts_o(rts), .comp_dtr_o(dtr),
      .core_tx_bit_i(tx_bit), .core_framing_ok_i(fr_ok), .core_rx_bit_o(rx_bit),
      .core_rx_valid_o(rx_val), .core_bit_tick_o(), .core_slot_o(), .core_frame_start_o(),
      .core_mgmt_slot_o(), .frame_lock_o(lock), .ch_path_valid_o(pval), .ch_start_o(),
      .ch_len_o(), .ch_sync_o(sync), .ch_txc_en_i(txc), .ch_from_link_i(from_l),
      .ch_far_rts_i(far_rts), .ch_to_link_o(to_l), .port_txd_i(ptxd), .port_txce_i(ptxce),
      .port_rts_i(prts), .port_rxd_o(prxd), .port_cts_o(cts), .port_dcd_o(dcd));
   dce_link_model u_dce_link_model (.run_i(run), .data_i(ldata), .rxc_o(rxc), .rxd_o(rxd));
   // ------------------------------
   // tasks
   // ------------------------------
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hf;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task wait_lock();
      for (int i = 0; i < 3000 && lock !== 1'b1; i++) @(posedge clk_i);
   endtask : wait_lock
   task final_report();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : final_report
   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      $display("watchdog expired");
      final_report();
   end
   // ------------------------------
   // tests
   // ------------------------------
   initial begin
      {cyc, stb, we, tx_bit, run} = '0;
      {fr_ok, ldata} = 2'h3;
      adr = 8'h00;
      sel = 4'hf;
      wdat = 32'h0;
      {txc, from_l, far_rts, ptxce, prts} = '0;
      ptxd = 16'hffff;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      run <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("dtr", 32'(dtr), 32'h1);
      chk("txd idle", 32'(txd), 32'h1);
      wb(1'b0, tdm_link_pkg::RATE_OFF, 32'h0);
      chk("rate reset", rdat, 32'h1);
      wb(1'b0, 8'h10, 32'h0);
      chk("unmapped", rdat, 32'h0);
      $display("test reset done");
      wb(1'b1, tdm_link_pkg::CTRL_OFF, 32'h3);
      repeat (2) @(posedge clk_i);
      chk("rts", 32'(rts), 32'h1);
      wait_lock();
      chk("lock", 32'(lock), 32'h1);
      repeat (5) @(posedge clk_i);
      chk("dcd lock", 32'(dcd), 32'hffff);
      wb(1'b1, 8'h44, 32'h0b);
      wb(1'b1, tdm_link_pkg::RATE_OFF, 32'h2);
      repeat (2) @(posedge clk_i);
      chk("rate unlock", 32'(lock), 32'h0);
      wb(1'b1, 8'h4c, 32'h3d);
      repeat (300) @(posedge clk_i);
      chk("no relock", 32'(lock), 32'h0);
      wb(1'b0, tdm_link_pkg::STAT_OFF, 32'h0);
      chk("lost flag", 32'(rdat[2]), 32'h1);
      wb(1'b0, 8'h44, 32'h0);
      chk("alloc kept", rdat & 32'h3ff, 32'h0b);
      wb(1'b1, tdm_link_pkg::RATE_OFF, 32'h1);
      repeat (5) @(posedge clk_i);
      chk("shrunk path", 32'(pval[1]), 32'h0);
      wb(1'b1, 8'h4c, 32'h0);
      wb(1'b1, 8'h4c, 32'h9);
      repeat (3) @(posedge clk_i);
      chk("realloc path", 32'(pval[1]), 32'h1);
      wait_lock();
      chk("relock", 32'(lock), 32'h1);
      fr_ok <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("framing lost", 32'(lock), 32'h0);
      fr_ok <= 1'b1;
      wait_lock();
      chk("framing relock", 32'(lock), 32'h1);
      $display("test rate done");
      tx_bit <= 1'b0;
      wb(1'b1, tdm_link_pkg::CTRL_OFF, 32'h9);
      // skip a strobe launched before the loop took hold
      @(posedge clk_i);
      for (int i = 0; i < 200 && rx_val !== 1'b1; i++) @(posedge clk_i);
      chk("tx loop", 32'(rx_bit), 32'h0);
      wb(1'b1, tdm_link_pkg::CTRL_OFF, 32'hd);
      wb(1'b0, tdm_link_pkg::CTRL_OFF, 32'h0);
      chk("loop excl", rdat & 32'hf, 32'h5);
      tx_bit <= 1'b1;
      ldata <= 1'b0;
      repeat (60) @(posedge clk_i);
      chk("rx loop", 32'(txd), 32'h0);
      ldata <= 1'b1;
      wb(1'b1, tdm_link_pkg::CTRL_OFF, 32'h0);
      repeat (2) @(posedge clk_i);
      chk("disable unlock", 32'(lock), 32'h0);
      repeat (100) @(posedge clk_i);
      chk("txd off", 32'(txd), 32'h1);
      chk("dcd off", 32'(dcd), 32'h0);
      $display("test composite done");
      ptxd[2] <= 1'b0;
      for (int k = 0; k < 3; k++) begin
         wb(1'b1, 8'h50, 32'h2000 * (k + 1));
         repeat (8) @(posedge clk_i);
         chk("port rxd", 32'(prxd[2]), 32'(erx[k]));
         chk("to link", 32'(to_l[2]), 32'(etl[k]));
      end
      wb(1'b1, 8'h58, 32'h200);
      prts[3] <= 1'b1;
      repeat (30) @(posedge clk_i);
      chk("cts early", 32'(cts[3]), 32'h0);
      repeat (60) @(posedge clk_i);
      chk("cts follow", 32'(cts[3]), 32'h1);
      prts[3] <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk("cts drop", 32'(cts[3]), 32'h0);
      wb(1'b1, 8'h58, 32'h80);
      repeat (6) @(posedge clk_i);
      chk("cts on", 32'(cts[3]), 32'h1);
      prts[3] <= 1'b1;
      wb(1'b1, 8'h58, 32'h100);
      repeat (6) @(posedge clk_i);
      chk("cts off", 32'(cts[3]), 32'h0);
      wb(1'b1, 8'h60, 32'h10);
      repeat (3) @(posedge clk_i);
      chk("hs sync", 32'(sync[4]), 32'h1);
      far_rts[5] <= 1'b1;
      wb(1'b1, 8'h68, 32'h1000);
      repeat (6) @(posedge clk_i);
      chk("dcd far", 32'(dcd), 32'h0020);
      $display("test channel done");
      final_report();
   end
endmodule : tdm_port_link_control_tb
